//--- hus_uart_host.sv
// host interface top: boot selection, uart with fifo, and host serial register port
// How it works
// - strap sampled once after reset; high selects card port, low selects uart.
// - card clock and command pins sampled at boot pick the uart protocol.
// - data on rx and tx; optional active-low rts and cts flow control.
// - baud divisor setting equals baud times 0.004096; 0x01d8 gives 115200.
// - eight data bits, parity none, odd or even, one or two stops.
// - rx held low longer than break timeout raises a reset request.
// - tx line can be forced low to send a wake-up break.
// - all serial outputs float while reset is held.
// - card data3 chip select, cmd mosi, data0 miso, clock sclk, data1 interrupt.
// - access opens with 8-bit command, 24-bit address, burst adds 16-bit length.
// - register cycles reach registers; burst cycles only target the buffer manager.
// - after write data an error byte is returned on miso.
// - a failed access through the serial port asserts the host interrupt.
// - read returns padding with miso low, error byte, then 16 data bits.
`timescale 1ns/100ps

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
module hus_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [WIDTH-1:0] rdata_o,
  output logic rvalid_o,
  input wire logic rready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  wire push = wvalid_i && wready_o;
  wire pop = rvalid_o && rready_i;
  assign wready_o = (count != (AW+1)'(DEPTH));
  assign rvalid_o = (count != '0);
  assign rdata_o = mem[rptr];
  // pointers and fill level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end
  // storage holds no reset, contents are only read behind rvalid
  always_ff @(posedge clk_i) begin
    if (push) mem[wptr] <= wdata_i;
  end
endmodule : hus_fifo

// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module hus_uart_host #(
  parameter int BREAK_UNIT = hus_pkg::BREAK_UNIT_CYCLES
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic host_select_strap_i,
  input wire logic card_clock_i,
  input wire logic card_command_i,
  input wire logic card_data_line_three_i,
  output logic card_data_line_zero_o,
  output logic card_data_line_zero_oe_n_o,
  output logic card_data_line_one_o,
  output logic card_data_line_one_oe_n_o,
  output logic card_port_sel_o,
  output hus_pkg::hus_proto_type protocol_o,
  input wire logic uart_rx_i,
  output logic uart_tx_o,
  output logic uart_tx_oe_n_o,
  output logic uart_rts_n_o,
  output logic uart_rts_oe_n_o,
  input wire logic uart_cts_n_i,
  input wire logic [15:0] baud_divisor_setting_i,
  input wire hus_pkg::hus_parity_type parity_mode_i,
  input wire logic two_stop_i,
  input wire logic flow_ctrl_en_i,
  input wire logic [15:0] break_reset_timeout_i,
  input wire logic send_break_i,
  output logic break_reset_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_parity_err_o,
  output logic rx_frame_err_o,
  input wire logic rx_ready_i,
  output logic [7:0] reg_cmd_o,
  output logic [23:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [15:0] reg_rdata_i,
  input wire logic reg_err_i,
  input wire logic int_clear_i
);
  import hus_pkg::*;

  // parity bit for a data byte under the chosen mode
  function automatic logic parity_of(input logic [7:0] d, input hus_parity_type m);
    parity_of = (m == PAR_ODD) ? ~(^d) : (^d);
  endfunction : parity_of

  // ----------------------------------------------------------------
  // reset release and boot straps
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  logic boot_done;
  // two-stage release so the async reset leaves cleanly
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end
  // straps are caught by a clocked capture on the first cycle after release
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      boot_done <= 1'b0;
      card_port_sel_o <= 1'b0;
      protocol_o <= PROTO_THREE_WIRE;
    end else if (!boot_done) begin
      boot_done <= 1'b1;
      card_port_sel_o <= host_select_strap_i;
      protocol_o <= hus_proto_type'({card_clock_i, card_command_i});
    end
  end
  wire uart_on = boot_done && !card_port_sel_o;
  wire card_on = boot_done && card_port_sel_o;
  // enables stay high (released) through reset and until the strap is known
  assign uart_tx_oe_n_o = !uart_on;
  assign uart_rts_oe_n_o = !uart_on;

  // ----------------------------------------------------------------
  // baud tick: four ticks per bit
  // ----------------------------------------------------------------
  logic [15:0] acc;
  wire [16:0] acc_sum = {1'b0, acc} + {1'b0, baud_divisor_setting_i};
  wire os_tick = (acc_sum >= {1'b0, BAUD_MOD});
  wire [15:0] next_acc = os_tick ? 16'(acc_sum - {1'b0, BAUD_MOD}) : acc_sum[15:0];
  // setting above the modulus would exceed the tick rate; 4 megabaud stays below
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) acc <= '0;
    else acc <= next_acc;
  end

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  logic [7:0] fifo_data;
  logic fifo_valid;
  hus_ser_state_type tx_state;
  logic [7:0] tx_shift;
  logic [2:0] tx_bit;
  logic [1:0] tx_os;
  logic tx_stop2;
  logic tx_line;
  wire cts_ok = !flow_ctrl_en_i || !uart_cts_n_i;
  wire tx_take = uart_on && tx_state == SER_IDLE && !send_break_i && cts_ok && fifo_valid;
  wire tx_bit_end = os_tick && tx_os == 2'h3;
  hus_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .wdata_i(tx_data_i),
    .wvalid_i(tx_valid_i),
    .wready_o(tx_ready_o),
    .rdata_o(fifo_data),
    .rvalid_o(fifo_valid),
    .rready_i(tx_take)
  );
  // framer; a break waits for the current character to finish
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= SER_IDLE;
      tx_shift <= '0;
      tx_bit <= '0;
      tx_os <= '0;
      tx_stop2 <= 1'b0;
      tx_line <= 1'b1;
    end else begin
      if (os_tick) tx_os <= tx_os + 1'b1;
      case (tx_state)
        SER_IDLE: begin
          tx_line <= !(send_break_i && uart_on);
          if (tx_take) begin
            tx_shift <= fifo_data;
            tx_state <= SER_START;
            tx_os <= '0;
            tx_line <= 1'b0;
          end
        end
        SER_START: if (tx_bit_end) begin
          tx_state <= SER_DATA;
          tx_bit <= '0;
          tx_line <= tx_shift[0];
        end
        SER_DATA: if (tx_bit_end) begin
          tx_bit <= tx_bit + 1'b1;
          tx_line <= tx_shift[3'(tx_bit + 1'b1)];
          if (tx_bit == 3'h7) begin
            tx_state <= (parity_mode_i == PAR_NONE) ? SER_STOP : SER_PARITY;
            tx_line <= (parity_mode_i == PAR_NONE) ? 1'b1 : parity_of(tx_shift, parity_mode_i);
            tx_stop2 <= two_stop_i;
          end
        end
        SER_PARITY: if (tx_bit_end) begin
          tx_state <= SER_STOP;
          tx_line <= 1'b1;
        end
        SER_STOP: if (tx_bit_end) begin
          tx_stop2 <= 1'b0;
          if (!tx_stop2) tx_state <= SER_IDLE;
        end
        default: tx_state <= SER_IDLE;
      endcase
    end
  end
  assign uart_tx_o = tx_line;

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  hus_ser_state_type rx_state;
  logic [7:0] rx_shift;
  logic [2:0] rx_bit;
  logic [1:0] rx_os;
  logic rx_par_bad;
  // sample about mid-bit: two ticks after the start low is seen, then every fourth tick
  wire rx_sample = os_tick && rx_os == 2'h1;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= SER_IDLE;
      rx_shift <= '0;
      rx_bit <= '0;
      rx_os <= '0;
      rx_par_bad <= 1'b0;
      rx_data_o <= '0;
      rx_valid_o <= 1'b0;
      rx_parity_err_o <= 1'b0;
      rx_frame_err_o <= 1'b0;
    end else begin
      if (os_tick) rx_os <= rx_os + 1'b1;
      if (rx_valid_o && rx_ready_i) rx_valid_o <= 1'b0;
      case (rx_state)
        SER_IDLE: if (uart_on && os_tick && !uart_rx_i) begin
          rx_state <= SER_START;
          rx_os <= '0;
        end
        SER_START: if (rx_sample) begin
          rx_state <= uart_rx_i ? SER_IDLE : SER_DATA;
          rx_bit <= '0;
        end
        SER_DATA: if (rx_sample) begin
          rx_shift <= {uart_rx_i, rx_shift[7:1]};
          rx_bit <= rx_bit + 1'b1;
          if (rx_bit == 3'h7) rx_state <= (parity_mode_i == PAR_NONE) ? SER_STOP : SER_PARITY;
          rx_par_bad <= 1'b0;
        end
        SER_PARITY: if (rx_sample) begin
          rx_par_bad <= (uart_rx_i != parity_of(rx_shift, parity_mode_i));
          rx_state <= SER_STOP;
        end
        SER_STOP: if (rx_sample) begin
          // a byte not yet taken is overwritten; rts holds the sender off first
          rx_state <= SER_IDLE;
          rx_data_o <= rx_shift;
          rx_valid_o <= 1'b1;
          rx_parity_err_o <= rx_par_bad;
          rx_frame_err_o <= !uart_rx_i;
        end
        default: rx_state <= SER_IDLE;
      endcase
    end
  end
  // request-to-send is low while the receive holding byte is free
  assign uart_rts_n_o = flow_ctrl_en_i && rx_valid_o;

  // ----------------------------------------------------------------
  // break detection on rx
  // ----------------------------------------------------------------
  logic [$clog2(BREAK_UNIT)-1:0] brk_cyc;
  logic [15:0] brk_units;
  logic brk_fired;
  wire unit_end = (brk_cyc == ($clog2(BREAK_UNIT))'(BREAK_UNIT - 1));
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      brk_cyc <= '0;
      brk_units <= '0;
      brk_fired <= 1'b0;
      break_reset_o <= 1'b0;
    end else begin
      break_reset_o <= 1'b0;
      if (!uart_on || uart_rx_i) begin
        brk_cyc <= '0;
        brk_units <= '0;
        brk_fired <= 1'b0;
      end else begin
        brk_cyc <= unit_end ? '0 : brk_cyc + 1'b1;
        if (unit_end && brk_units != 16'hffff) brk_units <= brk_units + 1'b1;
        // fires once per low stretch, longer than the timeout
        if (brk_units > break_reset_timeout_i && !brk_fired) begin
          brk_fired <= 1'b1;
          break_reset_o <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // host serial port: data3 select, cmd mosi, data0 miso, clock sclk
  // ----------------------------------------------------------------
  logic sclk_q;
  logic sclk_prev;
  logic mosi_q;
  logic [6:0] bit_cnt;
  logic [31:0] hdr;
  logic [15:0] wd;
  logic is_write;
  logic is_burst;
  logic [23:0] out_shift;
  logic miso;
  logic irq;
  // sclk is oversampled by mclk, so it must stay well below mclk / 4
  wire csb = card_data_line_three_i;
  wire sel = card_on && !csb;
  wire rise = sel && sclk_q && !sclk_prev;
  wire fall = sel && !sclk_q && sclk_prev;
  wire [31:0] hdr_next = {hdr[30:0], mosi_q};
  wire hdr_last = rise && bit_cnt == 7'(HDR_END - 1'b1);
  wire new_write = hdr_next[24 + CMD_WRITE_BIT];
  wire new_burst = hdr_next[24 + CMD_BURST_BIT];
  wire emit = is_write ? (bit_cnt >= WR_END) : (bit_cnt >= RD_ERR_START);
  wire access_done = reg_wr_o || reg_rd_o;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      sclk_prev <= 1'b0;
      mosi_q <= 1'b0;
    end else begin
      sclk_q <= card_clock_i;
      sclk_prev <= sclk_q;
      mosi_q <= card_command_i;
    end
  end
  // frame decode: mosi taken on sclk rising edges, miso changed on falling
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= '0;
      hdr <= '0;
      wd <= '0;
      is_write <= 1'b0;
      is_burst <= 1'b0;
      reg_cmd_o <= '0;
      reg_addr_o <= '0;
      reg_wdata_o <= '0;
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      out_shift <= '0;
      miso <= 1'b0;
    end else begin
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      if (!sel) begin
        bit_cnt <= '0;
        is_write <= 1'b0;
        miso <= 1'b0;
      end
      if (rise) begin
        if (bit_cnt != 7'h7f) bit_cnt <= bit_cnt + 1'b1;
        if (bit_cnt < HDR_END) hdr <= hdr_next;
        else if (bit_cnt < WR_END) wd <= {wd[14:0], mosi_q};
      end
      if (hdr_last) begin
        reg_cmd_o <= hdr_next[31:24];
        reg_addr_o <= hdr_next[23:0];
        is_write <= new_write;
        is_burst <= new_burst;
        reg_rd_o <= !new_write && !new_burst;
        // burst transfers belong to the buffer manager and are not served here
        if (new_burst) out_shift <= {ERR_BURST, 16'h0000};
      end
      if (rise && is_write && !is_burst && bit_cnt == 7'(WR_END - 1'b1)) begin
        reg_wdata_o <= {wd[14:0], mosi_q};
        reg_wr_o <= 1'b1;
      end
      // answer is taken in the strobe cycle, while the strobe is high
      if (access_done) out_shift <= {(reg_err_i ? ERR_FAIL : ERR_OK), (reg_rd_o ? reg_rdata_i : 16'h0000)};
      if (fall) begin
        miso <= emit ? out_shift[23] : 1'b0;
        if (emit) out_shift <= {out_shift[22:0], 1'b0};
      end
    end
  end
  // sticky host interrupt; a new failure wins over a clear in the same cycle
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) irq <= 1'b0;
    else if ((access_done && reg_err_i) || (hdr_last && new_burst)) irq <= 1'b1;
    else if (int_clear_i) irq <= 1'b0;
  end
  assign card_data_line_zero_o = miso;
  assign card_data_line_zero_oe_n_o = !sel;
  assign card_data_line_one_o = !irq;
  assign card_data_line_one_oe_n_o = !card_on;
endmodule : hus_uart_host

//--- hus_pkg.sv
// shared constants and types of the host uart and serial port block
package hus_pkg;
  // ----------------------------------------------------------------
  // clock and baud generation
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int OVERSAMPLE = 4;
  localparam int BAUD_SCALE = 4096;
  localparam int BAUD_UNIT_HZ = 1_000_000;
  // setting = baud * 0.004096, so one tick per setting step of the modulus
  localparam logic [15:0] BAUD_MOD = 16'((CLK_HZ / 1000) * BAUD_SCALE / (OVERSAMPLE * (BAUD_UNIT_HZ / 1000)));
  localparam logic [15:0] BAUD_SETTING_115200 = 16'h01d8;
  // break timeout counts in units of one millisecond
  localparam int BREAK_UNIT_US = 1000;
  localparam int BREAK_UNIT_CYCLES = (CLK_HZ / 1_000_000) * BREAK_UNIT_US;
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_BITS = 8;
  // ----------------------------------------------------------------
  // host serial port framing
  // ----------------------------------------------------------------
  localparam logic [6:0] HDR_END = 7'h20;
  localparam logic [6:0] WR_END = 7'h30;
  localparam int PAD_BYTES = 1;
  localparam logic [6:0] RD_ERR_START = 7'(32 + 8 * PAD_BYTES);
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_BURST_BIT = 1;
  localparam logic [7:0] ERR_OK = 8'h00;
  localparam logic [7:0] ERR_FAIL = 8'h01;
  localparam logic [7:0] ERR_BURST = 8'h02;
  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PROTO_THREE_WIRE = 2'b00, PROTO_H4 = 2'b01,
    PROTO_DEEP_SLEEP_H4 = 2'b10, PROTO_H5 = 2'b11} hus_proto_type;
  typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_ODD = 2'b01,
    PAR_EVEN = 2'b10} hus_parity_type;
  typedef enum logic [2:0] {SER_IDLE = 3'b000, SER_START = 3'b001, SER_DATA = 3'b010,
    SER_PARITY = 3'b011, SER_STOP = 3'b100} hus_ser_state_type;
endpackage : hus_pkg

//--- hus_host_model.sv
// behavioural host controller: uart sender and host serial port master
`timescale 1ns/100ps
module hus_host_model (
  input wire logic mclk_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic mosi_o,
  output logic cs_n_o,
  output logic rx_o
);
  // idle levels; only the host's own lines are driven, never the device's
  initial begin
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    cs_n_o = 1'b1;
    rx_o = 1'b1;
  end
  // strap levels on the shared clock and command pins
  task automatic straps(input logic [1:0] p);
    sclk_o <= p[1];
    mosi_o <= p[0];
  endtask : straps
  // line level, used for break
  task automatic rx_level(input logic v);
    @(posedge mclk_i);
    rx_o <= v;
  endtask : rx_level
  // one character, eight clocks a bit; bad flips the parity bit
  task automatic uart_send(input logic [7:0] d, input logic [1:0] par, input logic bad);
    logic [10:0] f;
    f = {1'b1, ((par == 2'b01) ? ~^d : ^d) ^ bad, d, 1'b0}; // low start, lsb first, high stop
    if (par == 2'b00) f[9] = 1'b1;
    for (int i = 0; i < ((par == 2'b00) ? 10 : 11); i++) begin
      @(posedge mclk_i);
      rx_o <= f[i];
      repeat (7) @(posedge mclk_i);
    end
  endtask : uart_send
  // 64 clocks: header and data out msb first, miso captured before each rise
  task automatic frame(input logic [63:0] d, output logic [63:0] q);
    @(posedge mclk_i);
    cs_n_o <= 1'b0; // select held low through the access
    mosi_o <= d[63];
    for (int i = 0; i < 64; i++) begin
      repeat (5) @(posedge mclk_i);
      q = {q[62:0], miso_i};
      sclk_o <= 1'b1; // command then address then data
      repeat (5) @(posedge mclk_i);
      sclk_o <= 1'b0;
      if (i < 63) mosi_o <= d[62 - i];
    end
    repeat (3) @(posedge mclk_i);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o; // released line carries no stale bit
    repeat (4) @(posedge mclk_i);
  endtask : frame
endmodule : hus_host_model

//--- hus_uart_host_sva.sv
// checker of the host interface top: reset float, mode, strobes, interrupt
`timescale 1ns/100ps
module hus_uart_host_sva #(
  parameter int BREAK_UNIT = 8
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic card_data_line_three_i,
  input wire logic card_data_line_zero_oe_n_o,
  input wire logic card_data_line_one_o,
  input wire logic card_data_line_one_oe_n_o,
  input wire logic card_port_sel_o,
  input wire logic uart_tx_oe_n_o,
  input wire logic uart_rts_n_o,
  input wire logic uart_rts_oe_n_o,
  input wire logic flow_ctrl_en_i,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic break_reset_o,
  input wire logic reg_wr_o,
  input wire logic reg_rd_o,
  input wire logic reg_err_i,
  input wire logic int_clear_i
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // one domain, so clock and disable are shared
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  // pins still float for two edges after release, the synchroniser lag
  property p_hiz;
    $rose(resetn_i) |-> (uart_tx_oe_n_o && uart_rts_oe_n_o && card_data_line_zero_oe_n_o
      && card_data_line_one_oe_n_o) [*2];
  endproperty
  a_hiz: assert property (p_hiz) else $error("serial pin driven in reset");
  property p_mode; !uart_tx_oe_n_o |-> !card_port_sel_o && card_data_line_one_oe_n_o; endproperty
  a_mode: assert property (p_mode) else $error("both host ports enabled");
  property p_rts; uart_rts_n_o == (flow_ctrl_en_i && rx_valid_o); endproperty
  a_rts: assert property (p_rts) else $error("rts level wrong");
  property p_rxhold; rx_valid_o && !rx_ready_i |=> rx_valid_o; endproperty
  a_rxhold: assert property (p_rxhold) else $error("unread byte dropped");
  property p_brk; break_reset_o |=> !break_reset_o; endproperty
  a_brk: assert property (p_brk) else $error("break reset longer than one cycle");
  property p_miso; card_data_line_three_i |-> card_data_line_zero_oe_n_o; endproperty
  a_miso: assert property (p_miso) else $error("miso driven while deselected");
  property p_nostb; !card_port_sel_o |-> !reg_wr_o && !reg_rd_o; endproperty
  a_nostb: assert property (p_nostb) else $error("register strobe in uart mode");
  property p_wr; reg_wr_o |=> !reg_wr_o && !reg_rd_o; endproperty
  a_wr: assert property (p_wr) else $error("write strobe too long");
  property p_irq; (reg_wr_o || reg_rd_o) && reg_err_i |-> ##[1:2] !card_data_line_one_o; endproperty
  a_irq: assert property (p_irq) else $error("failed access raised no interrupt");
  property p_clr;
    int_clear_i && card_data_line_three_i && !reg_wr_o && !reg_rd_o |-> ##[1:2] card_data_line_one_o;
  endproperty
  a_clr: assert property (p_clr) else $error("interrupt not cleared");
  c_wr: cover property (reg_wr_o);
  c_rd: cover property (reg_rd_o);
  c_brk: cover property (break_reset_o);
endmodule : hus_uart_host_sva
bind hus_uart_host hus_uart_host_sva #(.BREAK_UNIT(BREAK_UNIT)) u_sva (.*);

//--- test_host_uart_and_serial_port.sv
// self-checking bench of the host interface top
`timescale 1ns/100ps
module test_host_uart_and_serial_port;
  import hus_pkg::*;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic host_select_strap_i = 1'b0;
  logic uart_cts_n_i = 1'b0;
  logic [15:0] baud_divisor_setting_i = 16'h3200; // one tick every two clocks, eight clocks a bit
  hus_parity_type parity_mode_i = PAR_NONE;
  logic two_stop_i = 1'b0, flow_ctrl_en_i = 1'b0, send_break_i = 1'b0, tx_valid_i = 1'b0;
  logic rx_ready_i = 1'b0, reg_err_i = 1'b0, int_clear_i = 1'b0, ok;
  logic [15:0] break_reset_timeout_i = 16'h0003;
  logic [7:0] tx_data_i = 8'h00, rx_data_o, reg_cmd_o, d;
  logic [15:0] reg_rdata_i = 16'h0000, reg_wdata_o;
  wire card_clock_i, card_command_i, card_data_line_three_i, uart_rx_i;
  logic card_data_line_zero_o, card_data_line_zero_oe_n_o, card_data_line_one_o, card_data_line_one_oe_n_o;
  logic card_port_sel_o, uart_tx_o, uart_tx_oe_n_o, uart_rts_n_o, uart_rts_oe_n_o, break_reset_o, tx_ready_o;
  logic rx_valid_o, rx_parity_err_o, rx_frame_err_o, reg_wr_o, reg_rd_o;
  hus_proto_type protocol_o;
  logic [23:0] reg_addr_o;
  logic [63:0] cap;
  logic [11:0] fr;
  int errors = 0, tests_run = 0, wr_cnt = 0, rd_cnt = 0, brk_cnt = 0, k, n;
  // miso has a pull-up on the board
  wire miso_w = card_data_line_zero_oe_n_o ? 1'b1 : card_data_line_zero_o;
  hus_uart_host #(.BREAK_UNIT(8)) uut (.*);
  hus_host_model host (.mclk_i, .miso_i(miso_w), .sclk_o(card_clock_i), .mosi_o(card_command_i),
    .cs_n_o(card_data_line_three_i), .rx_o(uart_rx_i));
  // 25 MHz clock
  always #20 mclk_i = ~mclk_i;
  // strobe and pulse tallies
  always @(posedge mclk_i) begin
    if (reg_wr_o === 1'b1) wr_cnt++;
    if (reg_rd_o === 1'b1) rd_cnt++;
    if (break_reset_o === 1'b1) brk_cnt++;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // a wait that ran out ends the run
  task automatic limit(input int lim);
    if (k >= lim) begin
      check(0, 1);
      print_verdict();
    end
  endtask : limit
  task automatic boot(input logic s, input logic [1:0] p);
    @(posedge mclk_i);
    resetn_i <= 1'b0;
    host_select_strap_i <= s;
    host.straps(p);
    repeat (20) @(posedge mclk_i);
    check({uart_tx_oe_n_o, uart_rts_oe_n_o, card_data_line_zero_oe_n_o, card_data_line_one_oe_n_o}, 4'hf);
    resetn_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    check(card_port_sel_o, s);
    check(uart_tx_oe_n_o, s);
    if (!s) check(protocol_o, p);
  endtask : boot
  task automatic push(input logic [7:0] b, output logic taken);
    @(posedge mclk_i);
    tx_data_i <= b;
    tx_valid_i <= 1'b1;
    @(negedge mclk_i);
    taken = tx_ready_o;
    @(posedge mclk_i);
    tx_valid_i <= 1'b0;
  endtask : push
  // samples n bits of the next character at mid-bit
  task automatic get_tx(input int nb);
    fr = 12'hfff;
    for (k = 0; k < 4000 && uart_tx_o !== 1'b0; k++) @(negedge mclk_i);
    limit(4000);
    for (int i = 0; i < nb; i++) begin
      repeat (i ? 8 : 4) @(negedge mclk_i);
      fr[i] = uart_tx_o;
    end
  endtask : get_tx
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    for (int p = 0; p < 4; p++) boot(1'b0, 2'(p));
    // every parity mode with one and two stops
    for (int pm = 0; pm < 3; pm++) for (int ts = 0; ts < 2; ts++) begin
      d = 8'h96 + 8'(pm * 7 + ts);
      parity_mode_i <= hus_parity_type'(pm);
      two_stop_i <= ts[0];
      push(d, ok);
      get_tx(10 + (pm != 0) + ts);
      check(fr, {2'b11, (pm == 0) ? 1'b1 : (pm == 1) ? ~^d : ^d, d, 1'b0});
    end
    // receive, the last one with a wrong parity bit
    flow_ctrl_en_i <= 1'b1;
    for (int pm = 0; pm < 4; pm++) begin
      d = 8'h5a + 8'(pm);
      parity_mode_i <= (pm == 3) ? PAR_ODD : hus_parity_type'(pm);
      host.uart_send(d, (pm == 3) ? 2'b01 : 2'(pm), pm == 3);
      for (k = 0; k < 400 && rx_valid_o !== 1'b1; k++) @(negedge mclk_i);
      limit(400);
      check({rx_data_o, rx_frame_err_o}, {d, 1'b0});
      check(rx_parity_err_o, pm == 3);
      check(uart_rts_n_o, 1'b1);
      @(posedge mclk_i) rx_ready_i <= 1'b1;
      @(posedge mclk_i) rx_ready_i <= 1'b0;
    end
    // fill the fifo while cts holds the line, then drain in order
    parity_mode_i <= PAR_NONE;
    two_stop_i <= 1'b0;
    uart_cts_n_i <= 1'b1;
    n = 0;
    ok = 1'b1;
    for (int i = 0; i < 20 && ok; i++) begin
      push(8'h20 + 8'(i), ok);
      if (ok) n++;
    end
    check(n, FIFO_DEPTH);
    check(uart_tx_o, 1'b1);
    uart_cts_n_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      get_tx(10);
      check(fr[9:0], {1'b1, 8'h20 + 8'(i), 1'b0});
    end
    // short low is ignored, long low resets after four units
    rx_ready_i <= 1'b1;
    host.rx_level(1'b0);
    repeat (20) @(negedge mclk_i);
    host.rx_level(1'b1);
    repeat (16) @(negedge mclk_i);
    check(brk_cnt, 0);
    host.rx_level(1'b0);
    for (k = 0; k < 60 && brk_cnt == 0; k++) @(negedge mclk_i);
    check(k >= 31 && k <= 42, 1'b1);
    host.rx_level(1'b1);
    // wake-up break on tx
    @(posedge mclk_i) send_break_i <= 1'b1;
    repeat (6) @(negedge mclk_i);
    check(uart_tx_o, 1'b0);
    @(posedge mclk_i) send_break_i <= 1'b0;
    repeat (6) @(negedge mclk_i);
    check(uart_tx_o, 1'b1);
    host.frame({8'h01, 56'h0}, cap);
    check(wr_cnt, 0);
    // card mode register cycles
    boot(1'b1, 2'b00);
    host.frame({8'h01, 24'h123456, 16'hbeef, 16'h0000}, cap);
    check({reg_cmd_o, reg_addr_o}, {8'h01, 24'h123456});
    check({reg_wdata_o, cap[15:8]}, {16'hbeef, ERR_OK});
    check(wr_cnt, 1);
    reg_err_i <= 1'b1;
    host.frame({8'h01, 24'h000010, 16'h0001, 16'h0000}, cap);
    check(cap[15:8], ERR_FAIL);
    check(card_data_line_one_o, 1'b0);
    @(posedge mclk_i) int_clear_i <= 1'b1;
    @(posedge mclk_i) int_clear_i <= 1'b0;
    reg_err_i <= 1'b0;
    repeat (3) @(negedge mclk_i);
    check(card_data_line_one_o, 1'b1);
    reg_rdata_i <= 16'h5a3c;
    host.frame({8'h00, 24'habcdef, 32'h0}, cap);
    check(cap[31:0], {8'h00, ERR_OK, 16'h5a3c});
    check(rd_cnt, 1);
    host.frame({8'h02, 24'h000100, 32'h0}, cap);
    check(cap[23:16], ERR_BURST);
    check(wr_cnt + rd_cnt, 3);
    check(card_data_line_one_o, 1'b0);
    print_verdict();
  end
endmodule : test_host_uart_and_serial_port
